// ==== bench/sadc_link_chk.sv ====
// Checker for the four-wire converter link between host and device.
// Assumes it sits beside the link interface, on the system clock.
`timescale 1ns/1ps
module sadc_link_chk #(
    parameter int HALF_CYCLES = 6
) (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic dout,
    input wire logic dout_oe
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic sclk_q;
    logic [15:0] run;
    logic [7:0] rise_cnt;

    // Delayed link clock for edge detection
    always_ff @(posedge SYS_CLK_I) begin
        sclk_q <= SYS_RST_I ? 1'h0 : sclk;
    end

    // Cycles the link clock has stood still, saturating
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            run <= 16'hffff;
        end else if (sclk != sclk_q) begin
            run <= 16'h0000;
        end else if (run != 16'hffff) begin
            run <= run + 16'h0001;
        end
    end

    // Rising link clock edges within the current frame
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I || sel_n) begin
            rise_cnt <= 8'h00;
        end else if (sclk && !sclk_q) begin
            rise_cnt <= rise_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_start_bit;
        sclk && !sclk_q && !sel_n && rise_cnt == 8'h00 |-> serial_in;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("first clocked bit of a frame is not one");
    property p_addr_off;
        sclk && !sclk_q && !sel_n && rise_cnt < 8'h03 |-> !dout_oe;
    endproperty
    a_addr_off: assert property (p_addr_off)
        else $error("output driven during addressing");
    property p_idle_off;
        sel_n [*4] |-> !dout_oe;
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("output driven while deselected");
    property p_off_low;
        !dout_oe |-> !dout;
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("data high while output is off");
    property p_settle_zero;
        $rose(dout_oe) |-> !dout && !sel_n;
    endproperty
    a_settle_zero: assert property (p_settle_zero)
        else $error("output enabled without leading zero");
    property p_fall_edge;
        dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk;
    endproperty
    a_fall_edge: assert property (p_fall_edge)
        else $error("data changed while link clock high");
    property p_hold_low;
        $fell(dout_oe) |-> sel_n || $past(sel_n) || $past(sel_n, 2)
            || $past(sel_n, 3) || $past(sel_n, 4);
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("output released inside a frame");
    property p_half_period;
        sclk != sclk_q |-> 32'(run) >= HALF_CYCLES - 1;
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("link clock phase too short");
    property p_clk_still;
        sel_n [*3] |-> $stable(sclk);
    endproperty
    a_clk_still: assert property (p_clk_still)
        else $error("link clock moves outside a frame");
    property p_frame_len;
        $fell(sel_n) |-> ##[1:1000] sel_n;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame did not end in time");
    property p_tail_low;
        !sel_n && rise_cnt >= 8'h14 |-> dout_oe && !dout;
    endproperty
    a_tail_low: assert property (p_tail_low)
        else $error("output not held low after the last bit");
endmodule

// ==== bench/serial_adc_mux_sequencer_tb.sv ====
// Bench for the converter link: host and device joined by the interface.
// Assumes the package, link interface and both ends are compiled first.
`timescale 1ns/1ps
module serial_adc_mux_sequencer_tb;
    localparam int HALF = 6;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic start = 1'h0;
    logic se_sel = 1'h0;
    logic odd_sel = 1'h0;
    logic [7:0] ain0 = 8'h5a;
    logic [7:0] ain1 = 8'h33;
    logic [7:0] msb_data, lsb_data, result, expd;
    logic host_done, busy, dev_done;
    int dev_pulses = 0;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Design and checker
    // ------------------------------------------------------------
    sadc_link_if link();
    sadc_host #(.TWO_INPUT(1'h1), .HALF_CYCLES(HALF)) sadc_host_i (
        .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .LINK(link),
        .START_I(start), .SINGLE_ENDED_SEL_I(se_sel), .ODD_SEL_I(odd_sel),
        .MSB_DATA_O(msb_data), .LSB_DATA_O(lsb_data),
        .DONE_O(host_done), .BUSY_O(busy));
    sadc_device #(.TWO_INPUT(1'h1)) sadc_device_i (
        .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .LINK(link),
        .AIN0_I(ain0), .AIN1_I(ain1), .RESULT_O(result),
        .DONE_O(dev_done));
    sadc_link_chk #(.HALF_CYCLES(HALF)) sadc_link_chk_i (
        .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .sel_n(link.sel_n),
        .sclk(link.sclk), .serial_in(link.serial_in), .dout(link.dout),
        .dout_oe(link.dout_oe));

    // Clock and hang guard
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (dev_done === 1'h1) begin
            dev_pulses++;
        end
        if (cycles == 8000) begin
            miscompares++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    // Expected code: positive input minus negative, floored at zero
    function automatic logic [7:0] code(input logic se, input logic odd);
        logic [7:0] pos, neg;
        pos = odd ? ain1 : ain0;
        neg = se ? 8'h00 : (odd ? ain0 : ain1);
        return (pos < neg) ? 8'h00 : pos - neg;
    endfunction

    // One framed conversion with the given channel word
    task automatic convert(input logic se, input logic odd);
        int n;
        int pulses;
        @(negedge sys_clk);
        se_sel = se;
        odd_sel = odd;
        start = 1'h1;
        pulses = dev_pulses;
        expd = code(se, odd);
        @(negedge sys_clk);
        start = 1'h0;
        check({7'h00, busy}, 8'h01);
        n = 0;
        while (host_done !== 1'h1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        check({7'h00, host_done}, 8'h01);
        check(msb_data, expd);
        check(result, expd);
        check(8'(dev_pulses - pulses), 8'h01);
        check(lsb_data, expd);
        @(negedge sys_clk);
        check({7'h00, host_done}, 8'h00);
        check({7'h00, busy}, 8'h00);
        $display("test se=%b odd=%b code=%h done", se, odd, expd);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'h0;
        // Every channel word back to back, one negative difference
        for (int i = 3; i >= 0; i--) begin
            convert(i[1], i[0]);
        end
        ain0 = 8'hff;
        ain1 = 8'h00;
        convert(1'h0, 1'h0);
        convert(1'h1, 1'h1);
        summarize();
    end
endmodule

// ==== src/sadc_device.sv ====
// Converter end: start detection, channel word, settle, result stream.
// Assumes link pins are asynchronous to SYS_CLK_I; the comparator is
// modelled by comparing the two selected 8-bit analog codes.
`timescale 1ns/1ps

module sadc_device
    import sadc_pkg::*;
#(
    parameter bit TWO_INPUT = 1'b1
) (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    sadc_link_if.dev LINK,
    input wire logic [7:0] AIN0_I,
    input wire logic [7:0] AIN1_I,
    output logic [7:0] RESULT_O,
    output logic DONE_O
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sel_sync;
    logic [1:0] clk_sync;
    logic [1:0] din_sync;
    logic clk_prev;
    logic sel_n;
    logic rise;
    logic fall;

    // Two flops on each pin before use
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            sel_sync <= 2'h3;
            clk_sync <= 2'h0;
            din_sync <= 2'h0;
            clk_prev <= 1'b0;
        end else begin
            sel_sync <= {sel_sync[0], LINK.sel_n};
            clk_sync <= {clk_sync[0], LINK.sclk};
            din_sync <= {din_sync[0], LINK.serial_in};
            clk_prev <= clk_sync[1];
        end
    end

    assign sel_n = sel_sync[1];
    assign rise = clk_sync[1] & ~clk_prev;
    assign fall = ~clk_sync[1] & clk_prev;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    dev_state_t state;
    logic [ADDR_BITS-1:0] addr_sr;
    logic [1:0] addr_cnt;
    logic [4:0] bit_cnt;
    logic [7:0] approx_result_reg;
    logic [7:0] vpos;
    logic [7:0] vneg;
    logic [7:0] trial;
    logic decide;
    logic [7:0] next_sar;
    logic [2:0] replay_idx;

    // Channel assignment from the captured word
    always_comb begin
        vpos = AIN0_I;
        vneg = AIN1_I;
        if (!TWO_INPUT) begin
            vpos = AIN0_I; // fixed pair
            vneg = AIN1_I;
        end else if (addr_sr[1]) begin
            vpos = addr_sr[0] ? AIN1_I : AIN0_I;
            vneg = 8'h00;
        end else begin
            vpos = addr_sr[0] ? AIN1_I : AIN0_I;
            vneg = addr_sr[0] ? AIN0_I : AIN1_I;
        end
    end

    // Comparator: trial weight against the input difference
    always_comb begin
        trial = approx_result_reg | (8'h80 >> bit_cnt[2:0]);
        decide = (vpos >= vneg) && ((vpos - vneg) >= trial);
        next_sar = decide ? trial : approx_result_reg;
        // Replay counts 8..14 pick stored bits 1..7
        replay_idx = 3'(bit_cnt - 5'd7);
    end

    // State flow on link edges; select high forces idle
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            state <= DS_IDLE;
        end else if (sel_n) begin
            state <= DS_IDLE;
        end else begin
            case (state)
                DS_IDLE: begin
                    state <= DS_START;
                end
                DS_START: begin
                    if (rise && din_sync[1]) begin
                        state <= TWO_INPUT ? DS_ADDR : DS_SETTLE;
                    end
                end
                DS_ADDR: begin
                    if (rise && addr_cnt == 2'd1) begin
                        state <= DS_SETTLE;
                    end
                end
                DS_SETTLE: begin
                    if (fall) begin
                        state <= DS_CONV;
                    end
                end
                DS_CONV: begin
                    if (fall && bit_cnt == (TWO_INPUT ? 5'd15 : 5'd8)) begin
                        state <= DS_TAIL;
                    end
                end
                DS_TAIL: begin
                    state <= DS_TAIL;
                end
                default: begin
                    state <= DS_IDLE;
                end
            endcase
        end
    end

    // Channel word capture, only while addressing
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I || sel_n || state == DS_START) begin
            addr_cnt <= 2'd0;
            if (SYS_RST_I || sel_n) begin
                addr_sr <= 2'b00;
            end
        end else if (state == DS_ADDR && rise) begin
            addr_sr <= {addr_sr[0], din_sync[1]};
            addr_cnt <= addr_cnt + 2'd1;
        end
    end

    // Approximation and output bit count
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I || sel_n || state == DS_START) begin
            approx_result_reg <= RESULT_RESET;
            bit_cnt <= BIT_CNT_RESET;
        end else if (state == DS_CONV && fall) begin
            bit_cnt <= bit_cnt + 5'd1;
            // All eight decisions kept so the replay has a full word
            if (bit_cnt < 5'd8) begin
                approx_result_reg <= next_sar;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial output driver
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I || sel_n) begin
            LINK.dout <= 1'b0;
            LINK.dout_oe <= 1'b0;
        end else begin
            case (state)
                DS_SETTLE: begin
                    LINK.dout <= 1'b0;
                    LINK.dout_oe <= 1'b1;
                end
                DS_CONV: begin
                    if (fall) begin
                        if (bit_cnt < 5'd8) begin
                            LINK.dout <= decide;
                        end else if (TWO_INPUT && bit_cnt < 5'd15) begin
                            LINK.dout <= approx_result_reg[replay_idx];
                        end else begin
                            // Last bit done: low until deselect
                            LINK.dout <= 1'b0;
                        end
                    end
                end
                DS_TAIL: begin
                    LINK.dout <= 1'b0;
                end
                default: begin
                    LINK.dout <= 1'b0;
                    LINK.dout_oe <= 1'b0;
                end
            endcase
        end
    end

    // Result capture once the eighth decision is made
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            RESULT_O <= RESULT_RESET;
            DONE_O <= 1'b0;
        end else begin
            DONE_O <= 1'b0;
            if (state == DS_CONV && fall && bit_cnt == 5'd7) begin
                RESULT_O <= next_sar;
                DONE_O <= 1'b1;
            end
        end
    end

endmodule

// ==== src/sadc_host.sv ====
// Host end: frames a conversion, sends start and channel word, reads bits.
// Assumes the device end runs on the same system clock.
`timescale 1ns/1ps
module sadc_host
    import sadc_pkg::*;
#(
    parameter bit TWO_INPUT = 1'b1,
    parameter int HALF_CYCLES = HALF_PERIOD_CYCLES
) (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    sadc_link_if.host LINK,
    input wire logic START_I,
    input wire logic SINGLE_ENDED_SEL_I,
    input wire logic ODD_SEL_I,
    output logic [7:0] MSB_DATA_O,
    output logic [7:0] LSB_DATA_O,
    output logic DONE_O,
    output logic BUSY_O
);

    // ------------------------------------------------------------
    // Link clock divider, at most the device maximum rate
    // ------------------------------------------------------------
    host_state_t state;
    logic [7:0] div_cnt;
    logic [4:0] edge_cnt;
    logic [2:0] tx_word;
    logic [15:0] rx_sr;
    logic tick;
    logic [1:0] dout_sync;
    logic [7:0] replay;

    assign tick = (div_cnt == 8'(HALF_CYCLES - 1));

    // Replay reassembled into a word; its first bit is the shared LSB
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            replay[i] = rx_sr[8 - i];
        end
    end

    // Two flops on the returning data pin
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            dout_sync <= 2'h0;
        end else begin
            dout_sync <= {dout_sync[0], LINK.dout};
        end
    end

    // Divider runs only while framed
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I || state == HS_IDLE || tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            state <= HS_IDLE;
            LINK.sel_n <= 1'b1;
            LINK.sclk <= 1'b0;
            LINK.serial_in <= 1'b0;
            edge_cnt <= 5'd0;
            tx_word <= 3'b000;
            rx_sr <= 16'h0000;
            MSB_DATA_O <= 8'h00;
            LSB_DATA_O <= 8'h00;
            DONE_O <= 1'b0;
            BUSY_O <= 1'b0;
        end else begin
            DONE_O <= 1'b0;
            case (state)
                HS_IDLE: begin
                    if (START_I) begin
                        LINK.sel_n <= 1'b0;
                        tx_word <= {1'b1, SINGLE_ENDED_SEL_I, ODD_SEL_I};
                        LINK.serial_in <= 1'b1;
                        edge_cnt <= 5'd0;
                        BUSY_O <= 1'b1;
                        state <= HS_SEND;
                    end
                end
                HS_SEND, HS_RECV: begin
                    if (tick) begin
                        LINK.sclk <= ~LINK.sclk;
                        if (LINK.sclk) begin
                            // Falling edge: advance data, count periods
                            edge_cnt <= edge_cnt + 5'd1;
                            tx_word <= {tx_word[1:0], 1'b0};
                            LINK.serial_in <= tx_word[1];
                            if (edge_cnt == (TWO_INPUT ? 5'd2 : 5'd0)) begin
                                state <= HS_RECV;
                            end
                            if (edge_cnt == (TWO_INPUT ? 5'd19 : 5'd9)) begin
                                state <= HS_DONE;
                            end
                        end else if (state == HS_RECV
                                     && edge_cnt > (TWO_INPUT ? 5'd3 : 5'd1)) begin
                            rx_sr <= {rx_sr[14:0], dout_sync[1]};
                        end
                    end
                end
                HS_DONE: begin
                    LINK.sel_n <= 1'b1;
                    LINK.sclk <= 1'b0;
                    MSB_DATA_O <= TWO_INPUT ? rx_sr[15:8] : rx_sr[7:0];
                    LSB_DATA_O <= TWO_INPUT ? replay : 8'h00;
                    DONE_O <= 1'b1;
                    BUSY_O <= 1'b0;
                    state <= HS_IDLE;
                end
                default: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

endmodule

// ==== src/sadc_link_if.sv ====
// Four-wire link between host and converter sequencer.
// Assumes the bench resolves dout from its enable.
`timescale 1ns/1ps
interface sadc_link_if;
    logic sel_n;
    logic sclk;
    logic serial_in;
    logic dout;
    logic dout_oe;

    modport host (output sel_n, output sclk, output serial_in,
                  input dout, input dout_oe);
    modport dev (input sel_n, input sclk, input serial_in,
                 output dout, output dout_oe);
endinterface

// ==== src/sadc_pkg.sv ====
// Package for the serial converter link: widths, cycle counts, states.
// Assumes a single 100 MHz system clock shared by both ends.
package sadc_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int RESULT_BITS = 8;
    localparam int ADDR_BITS = 2;
    localparam int SYS_CLK_MHZ = 100;
    localparam int LINK_CLK_KHZ = 2000;
    localparam int HALF_PERIOD_CYCLES = (SYS_CLK_MHZ * 1000)
        / (2 * LINK_CLK_KHZ);
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [4:0] BIT_CNT_RESET = 5'h00;

    // ------------------------------------------------------------
    // Device sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        DS_IDLE   = 6'b00_0001,
        DS_START  = 6'b00_0010,
        DS_ADDR   = 6'b00_0100,
        DS_SETTLE = 6'b00_1000,
        DS_CONV   = 6'b01_0000,
        DS_TAIL   = 6'b10_0000
    } dev_state_t;

    // ------------------------------------------------------------
    // Host sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_SEND = 4'b0010,
        HS_RECV = 4'b0100,
        HS_DONE = 4'b1000
    } host_state_t;

endpackage
